/* mqp_pkg.sv */
/*
  Package for the MAC queue pointer block: register offsets, field layout,
  reset value, event bits, the status entry and state types, and helpers.
  Assumes one APB slave with 32-bit data and a 12-bit byte address.
*/
package mqp_pkg;

  // ---------------------------------------------------------------------------
  // Register indices in bits 7:0; the byte address is four times that index.
  // ---------------------------------------------------------------------------
  localparam logic [31:0] OFS_RX_STS_BASE  = 32'h800100a0;
  localparam logic [31:0] OFS_RX_STS_SIZE  = 32'h800100a4;
  localparam logic [31:0] OFS_RX_STS_REM   = 32'h800100a6;
  localparam logic [31:0] OFS_RX_STS_PTR   = 32'h800100a8;
  localparam logic [31:0] OFS_RX_STS_FREE  = 32'h800100ac;
  localparam logic [31:0] OFS_TX_DQ_BASE   = 32'h800100b0;
  localparam logic [31:0] OFS_TX_DQ_SIZE   = 32'h800100b4;
  localparam logic [31:0] OFS_TX_DQ_REM    = 32'h800100b6;
  localparam logic [31:0] OFS_TX_DQ_PTR    = 32'h800100b8;
  localparam logic [31:0] OFS_RX_HDR_LEN   = 32'h800100ec;
  localparam logic [31:0] OFS_EVENT_STATUS = 32'h800100f0;
  localparam logic [31:0] OFS_EVENT_MASK   = 32'h800100f4;

  // ---------------------------------------------------------------------------
  // Field layout and reset value.
  // ---------------------------------------------------------------------------
  localparam int          LEN_W          = 16;
  localparam int          HDR_W          = 10;
  localparam int          HDR1_LSB       = 0;
  localparam int          HDR2_LSB       = 16;
  localparam int          FREE_INC_W     = 8;
  localparam int          FREE_VAL_LSB   = 16;
  localparam int          AM_W           = 3;
  localparam logic [31:0] REG_RESET      = 32'h00000000;
  localparam logic [15:0] STS_ENTRY_BYTES = 16'h0008;

  // Event bits of the event status and mask registers.
  localparam int EV_W          = 4;
  localparam int EV_HDR        = 0;
  localparam int EV_RX_WRAP    = 1;
  localparam int EV_TX_WRAP    = 2;
  localparam int EV_FREE_EMPTY = 3;

  // ---------------------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [12:0]     zero;
    logic [AM_W-1:0] addr_match;
    logic [15:0]     byte_count;
  } mqp_sts_s;

  typedef struct packed {
    logic [31:0] ptr;
    logic [15:0] rem;
    logic        wrap;
  } mqp_adv_s;

  typedef struct packed {
    logic [31:0]      rx_base;
    logic [15:0]      rx_size;
    logic [15:0]      rx_rem;
    logic [31:0]      rx_ptr;
    logic [15:0]      free_cnt;
    logic [HDR_W-1:0] hdr1;
    logic [HDR_W-1:0] hdr2;
    logic [31:0]      tx_base;
    logic [15:0]      tx_size;
    logic [15:0]      tx_rem;
    logic [31:0]      tx_ptr;
    logic [15:0]      frame_bytes;
    logic             h1_pend;
    logic             h2_pend;
    mqp_sts_s         h1_word;
    mqp_sts_s         h2_word;
    logic             sts_req;
    logic             sts_sel2;
    mqp_sts_s         sts_word;
    logic [31:0]      sts_addr;
    logic [EV_W-1:0]  ev_stat;
    logic [EV_W-1:0]  ev_mask;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } mqp_state_s;

  // ---------------------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------------------
  // Moves a queue pointer by step bytes and wraps it to base at the queue end.
  function automatic mqp_adv_s mqp_advance(input logic [31:0] ptr,
                                           input logic [15:0] rem,
                                           input logic [31:0] base,
                                           input logic [15:0] size,
                                           input logic [15:0] step);
    mqp_adv_s r;
    r.wrap = (step >= rem);
    r.ptr  = r.wrap ? base : ptr + {16'h0000, step};
    r.rem  = r.wrap ? size : rem - step;
    return r;
  endfunction

  // True when the byte count passes a threshold in this update.
  function automatic logic mqp_crossed(input logic [15:0]      old_cnt,
                                       input logic [15:0]      new_cnt,
                                       input logic [HDR_W-1:0] thr);
    logic [15:0] t;
    t = {6'h00, thr};
    return (old_cnt < t) && (new_cnt >= t);
  endfunction

  // Decodes one register from a 12-bit APB byte address.
  function automatic logic mqp_hit(input logic [11:0] addr, input logic [31:0] ofs);
    return (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) && (addr[9:2] == ofs[7:0]);
  endfunction

endpackage

/* mqp_queue_ptr.sv */
/*
  MAC queue pointer block: receive status queue pointer and free-entry count,
  receive header status generation, transmit descriptor queue pointer, an
  event status/mask pair with one interrupt, and an APB register slave.
  Assumes the MAC data path and bus master run on pclk, so their strobes
  need no synchronisers, and that the bus master acknowledges each status.
*/
`timescale 1ns/1ps
module mqp_queue_ptr (
  input  wire  logic                    pclk,
  input  wire  logic                    presetn,
  input  wire  logic                    psel,
  input  wire  logic                    penable,
  input  wire  logic                    pwrite,
  input  wire  logic [11:0]             paddr,
  input  wire  logic [31:0]             pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire  logic                    rx_frame_start,
  input  wire  logic                    rx_bytes_valid,
  input  wire  logic [15:0]             rx_bytes_add,
  input  wire  logic [mqp_pkg::AM_W-1:0] rx_addr_match,
  output logic                          sts_req,
  output logic [31:0]                   sts_addr,
  output mqp_pkg::mqp_sts_s             sts_entry,
  input  wire  logic                    sts_wr_done,
  input  wire  logic                    tx_fetch_done,
  input  wire  logic [15:0]             tx_fetch_bytes,
  output logic [31:0]                   tx_fetch_addr,
  output logic                          irq
);
  import mqp_pkg::*;

  mqp_state_s      s_r;
  mqp_state_s      s_nxt;
  logic            setup;
  logic            done;

  // ---------------------------------------------------------------------------
  // Bus phase decode.
  // ---------------------------------------------------------------------------
  // The slave answers in the first access cycle; pready was loaded at setup.
  assign setup = psel & ~penable;
  assign done  = psel & penable & s_r.pready;

  // ---------------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------------
  // All updates are computed here; later assignments take priority.
  always_comb begin
    mqp_adv_s        adv;
    logic [EV_W-1:0] ev;
    logic [15:0]     sum;
    logic [15:0]     inc;
    logic [15:0]     dec;
    logic [31:0]     rd;
    logic            hit;
    mqp_sts_s        word;
    adv  = '0;
    ev   = '0;
    sum  = '0;
    inc  = '0;
    dec  = '0;
    rd   = '0;
    hit  = 1'b0;
    word = '0;
    s_nxt = s_r;

    // Each descriptor fetch moves the read pointer; prefetch steps need not
    // be whole descriptors, so the step is taken as given.
    if (tx_fetch_done) begin
      adv = mqp_advance(s_r.tx_ptr, s_r.tx_rem, s_r.tx_base, s_r.tx_size,
                        tx_fetch_bytes);
      s_nxt.tx_ptr = adv.ptr;
      s_nxt.tx_rem = adv.rem;
      if (adv.wrap) begin
        ev[EV_TX_WRAP] = 1'b1;
      end
    end

    // A completed status write moves the status pointer and uses one entry.
    if (s_r.sts_req && sts_wr_done) begin
      adv = mqp_advance(s_r.rx_ptr, s_r.rx_rem, s_r.rx_base, s_r.rx_size,
                        STS_ENTRY_BYTES);
      s_nxt.rx_ptr = adv.ptr;
      s_nxt.rx_rem = adv.rem;
      if (adv.wrap) begin
        ev[EV_RX_WRAP] = 1'b1;
      end
      dec = 16'h0001;
      if (s_r.sts_sel2) begin
        s_nxt.h2_pend = 1'b0;
      end else begin
        s_nxt.h1_pend = 1'b0;
      end
    end

    // Header status capture; a new capture wins over the clear above.
    if (rx_frame_start) begin
      s_nxt.frame_bytes = '0;
    end else if (rx_bytes_valid) begin
      sum = s_r.frame_bytes + rx_bytes_add;
      s_nxt.frame_bytes = sum;
      word.zero       = '0;
      word.addr_match = rx_addr_match;
      word.byte_count = sum;
      if (s_r.hdr1 != '0 && mqp_crossed(s_r.frame_bytes, sum, s_r.hdr1)) begin
        s_nxt.h1_pend = 1'b1;
        s_nxt.h1_word = word;
        ev[EV_HDR]    = 1'b1;
      end
      if (s_r.hdr2 > s_r.hdr1 && mqp_crossed(s_r.frame_bytes, sum, s_r.hdr2)) begin
        s_nxt.h2_pend = 1'b1;
        s_nxt.h2_word = word;
        ev[EV_HDR]    = 1'b1;
      end
    end

    // APB answer, loaded in the setup cycle and shown in the access cycle.
    s_nxt.pready  = setup;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata  = '0;
    if (setup) begin
      hit = 1'b1;
      if (mqp_hit(paddr, OFS_RX_STS_BASE)) begin
        rd = s_r.rx_base;
      end else if (mqp_hit(paddr, OFS_RX_STS_SIZE)) begin
        rd = {16'h0000, s_r.rx_size};
      end else if (mqp_hit(paddr, OFS_RX_STS_REM)) begin
        rd = {16'h0000, s_r.rx_rem};
      end else if (mqp_hit(paddr, OFS_RX_STS_PTR)) begin
        rd = s_r.rx_ptr;
      end else if (mqp_hit(paddr, OFS_RX_STS_FREE)) begin
        rd = {s_r.free_cnt, 16'h0000};                                     // Increment reads 0.
      end else if (mqp_hit(paddr, OFS_TX_DQ_BASE)) begin
        rd = s_r.tx_base;
      end else if (mqp_hit(paddr, OFS_TX_DQ_SIZE)) begin
        rd = {16'h0000, s_r.tx_size};
      end else if (mqp_hit(paddr, OFS_TX_DQ_REM)) begin
        rd = {16'h0000, s_r.tx_rem};
      end else if (mqp_hit(paddr, OFS_TX_DQ_PTR)) begin
        rd = s_r.tx_ptr;
      end else if (mqp_hit(paddr, OFS_RX_HDR_LEN)) begin
        rd = {6'h00, s_r.hdr2, 6'h00, s_r.hdr1};
      end else if (mqp_hit(paddr, OFS_EVENT_STATUS)) begin
        rd = {28'h0000000, s_r.ev_stat};
      end else if (mqp_hit(paddr, OFS_EVENT_MASK)) begin
        rd = {28'h0000000, s_r.ev_mask};
      end else begin
        hit = 1'b0;
      end
      s_nxt.pslverr = ~hit;
      s_nxt.prdata  = pwrite ? 32'h00000000 : rd;
    end

    // Reading the event status clears only the bits that were returned, so
    // an event landing during the access is kept for the next read.
    if (done && !pwrite && mqp_hit(paddr, OFS_EVENT_STATUS)) begin
      s_nxt.ev_stat = s_r.ev_stat & ~s_r.prdata[EV_W-1:0];
    end

    // Register writes take effect at the completing edge and override the
    // hardware update of the same cycle, except the free count, which applies both.
    if (done && pwrite) begin
      if (mqp_hit(paddr, OFS_RX_STS_BASE)) begin
        s_nxt.rx_base = pwdata;
      end
      if (mqp_hit(paddr, OFS_RX_STS_SIZE)) begin
        s_nxt.rx_size = pwdata[LEN_W-1:0];
      end
      if (mqp_hit(paddr, OFS_RX_STS_REM)) begin
        s_nxt.rx_rem = pwdata[LEN_W-1:0];
      end
      if (mqp_hit(paddr, OFS_RX_STS_PTR)) begin
        s_nxt.rx_ptr = pwdata;
      end
      if (mqp_hit(paddr, OFS_RX_STS_FREE)) begin
        inc = {8'h00, pwdata[FREE_INC_W-1:0]};
      end
      if (mqp_hit(paddr, OFS_TX_DQ_BASE)) begin
        s_nxt.tx_base = pwdata;
      end
      if (mqp_hit(paddr, OFS_TX_DQ_SIZE)) begin
        s_nxt.tx_size = pwdata[LEN_W-1:0];
      end
      if (mqp_hit(paddr, OFS_TX_DQ_REM)) begin
        s_nxt.tx_rem = pwdata[LEN_W-1:0];
      end
      if (mqp_hit(paddr, OFS_TX_DQ_PTR)) begin
        s_nxt.tx_ptr = pwdata;
      end
      if (mqp_hit(paddr, OFS_RX_HDR_LEN)) begin
        s_nxt.hdr1 = pwdata[HDR1_LSB +: HDR_W];
        s_nxt.hdr2 = pwdata[HDR2_LSB +: HDR_W];
      end
      if (mqp_hit(paddr, OFS_EVENT_MASK)) begin
        s_nxt.ev_mask = pwdata[EV_W-1:0];
      end
    end

    // Free count adds the increment and subtracts the written entry at once.
    s_nxt.free_cnt = s_r.free_cnt + inc - dec;
    if (s_r.free_cnt != '0 && s_nxt.free_cnt == '0) begin
      ev[EV_FREE_EMPTY] = 1'b1;
    end

    // A status offered to the bus master stays unchanged until it is written;
    // otherwise the header 1 status, if pending, is offered before header 2 when room exists.
    if (!(s_r.sts_req && !sts_wr_done)) begin
      s_nxt.sts_req  = (s_nxt.h1_pend | s_nxt.h2_pend)
                       && (s_nxt.free_cnt != '0);
      s_nxt.sts_sel2 = ~s_nxt.h1_pend;
      s_nxt.sts_word = s_nxt.h1_pend ? s_nxt.h1_word : s_nxt.h2_word;
      s_nxt.sts_addr = s_nxt.rx_ptr;
    end

    // Sticky events: a set in the clearing cycle wins.
    s_nxt.ev_stat = s_nxt.ev_stat | ev;
    s_nxt.irq     = |(s_nxt.ev_stat & s_nxt.ev_mask);
  end

  // ---------------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------------
  // Chip reset clears everything; there is no soft reset path here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= mqp_state_s'({$bits(mqp_state_s){1'b0}});
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, each taken straight from the state register.
  // ---------------------------------------------------------------------------
  assign prdata        = s_r.prdata;
  assign pready        = s_r.pready;
  assign pslverr       = s_r.pslverr;
  assign sts_req       = s_r.sts_req;
  assign sts_addr      = s_r.sts_addr;
  assign sts_entry     = s_r.sts_word;
  assign tx_fetch_addr = s_r.tx_ptr;
  assign irq           = s_r.irq;

endmodule

/* mqp_queue_ptr_monitor.sv */
/* Checker for the queue pointer block: bus timing, status hold, interrupt.
   Assumes it is bound to mqp_queue_ptr and sees only its ports. */
`timescale 1ns/1ps
module mqp_queue_ptr_monitor (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              rx_bytes_valid,
  input wire logic              sts_req,
  input wire logic [31:0]       sts_addr,
  input wire mqp_pkg::mqp_sts_s sts_entry,
  input wire logic              sts_wr_done,
  input wire logic              tx_fetch_done,
  input wire logic [31:0]       tx_fetch_addr,
  input wire logic              irq
);
  import mqp_pkg::*;
  logic cause;
  logic acc;
  // A status may only follow moved bytes, a write or a finished entry.
  assign cause = rx_bytes_valid || (psel && penable && pwrite) || sts_wr_done;
  assign acc   = psel && penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_data_a: assert property (!pready || pwrite |-> prdata == 32'h0)
    else $error("read data outside a read");
  irq_sticky_a: assert property (irq && !acc && !$past(acc) |=> irq)
    else $error("interrupt dropped without access");
  status_hold_a: assert property (sts_req && !sts_wr_done && !psel |=>
    sts_req && $stable(sts_addr) && $stable(sts_entry)) else $error("status not held");
  status_zero_a: assert property (sts_req |-> sts_entry.zero == 13'h0)
    else $error("status spare bits set");
  status_cause_a: assert property ($rose(sts_req) |-> $past(cause) || $past(cause, 2))
    else $error("status without cause");
  fetch_hold_a: assert property (!tx_fetch_done && !(psel && pwrite) |=>
    $stable(tx_fetch_addr)) else $error("fetch pointer moved alone");
endmodule
bind mqp_queue_ptr mqp_queue_ptr_monitor u_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_bytes_valid(rx_bytes_valid),
  .sts_req(sts_req), .sts_addr(sts_addr), .sts_entry(sts_entry), .sts_wr_done(sts_wr_done),
  .tx_fetch_done(tx_fetch_done), .tx_fetch_addr(tx_fetch_addr), .irq(irq));

/* mqp_mem_model.sv */
/* Memory-side bus master that acknowledges receive status entries.
   Assumes a request stands until its done pulse is seen. */
`timescale 1ns/1ps
module mqp_mem_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sts_req,
  input  wire logic [1:0] slow,
  output logic            sts_wr_done
);
  logic [1:0] wait_r;
  // Done follows slow idle cycles and only while a request stands, so no
  // entry is acknowledged twice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r      <= 2'h0;
      sts_wr_done <= 1'b0;
    end else if (sts_req && !sts_wr_done && wait_r == slow) begin
      wait_r      <= 2'h0;
      sts_wr_done <= 1'b1;
    end else begin
      sts_wr_done <= 1'b0;
      wait_r      <= (sts_req && !sts_wr_done) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule

/* mqp_queue_ptr_bench.sv */
/* Self-checking bench for the queue pointer block with a reference model.
   Assumes package, design, checker and memory model compile first. */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module mqp_queue_ptr_bench;
  import mqp_pkg::*;
  localparam logic [31:0] RXB = 32'h2000, RXS = 32'h10, TXB = 32'h1000, TXS = 32'h40;
  localparam logic [31:0] REGS [12] = '{OFS_RX_STS_BASE, OFS_RX_STS_SIZE, OFS_RX_STS_REM,
    OFS_RX_STS_PTR, OFS_RX_STS_FREE, OFS_TX_DQ_BASE, OFS_TX_DQ_SIZE, OFS_TX_DQ_REM,
    OFS_TX_DQ_PTR, OFS_RX_HDR_LEN, OFS_EVENT_STATUS, OFS_EVENT_MASK};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic        rx_frame_start = 0, rx_bytes_valid = 0, tx_fetch_done = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, sts_addr, tx_fetch_addr, rd, seed = 32'h1bb1;
  logic [15:0] rx_bytes_add = 0, tx_fetch_bytes = 0;
  logic [2:0]  rx_addr_match = 0;
  logic [1:0]  slow = 0;
  logic        pready, pslverr, sts_req, sts_wr_done, irq;
  mqp_sts_s    sts_entry;
  logic [31:0] rx_ptr, rx_rem, tx_ptr, tx_rem, free = 0, ev = 0, exp_q [$];
  int          miscompares = 0, checked = 0, cyc = 0, hdr1, hdr2, cnt;
  mqp_queue_ptr dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_frame_start(rx_frame_start), .rx_bytes_valid(rx_bytes_valid),
    .rx_bytes_add(rx_bytes_add), .rx_addr_match(rx_addr_match), .sts_req(sts_req),
    .sts_addr(sts_addr), .sts_entry(sts_entry), .sts_wr_done(sts_wr_done),
    .tx_fetch_done(tx_fetch_done), .tx_fetch_bytes(tx_fetch_bytes),
    .tx_fetch_addr(tx_fetch_addr), .irq(irq));
  mqp_mem_model u_mem (.pclk(pclk), .presetn(presetn), .sts_req(sts_req), .slow(slow),
    .sts_wr_done(sts_wr_done));
  // ---------------------------------------------------------------------------
  // Clock, timeout and helpers.
  // ---------------------------------------------------------------------------
  always #12.5 pclk = ~pclk;
  // A hang counts as a mismatch and closes the run.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One APB transfer; the request holds until ready is sampled high at a
  // rising edge, and the answer is taken at that same edge, never later.
  task automatic apb(input logic w, input logic [31:0] ofs, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, ofs[7:0], 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input int h1, input int h2);
    hdr1 = h1;
    hdr2 = h2;
    cnt  = 0;
    seed = lfsr(seed);
    apb(1'b1, OFS_RX_HDR_LEN, (h2 << 16) | h1);
    @(posedge pclk);
    rx_frame_start <= 1'b1;
    rx_addr_match  <= seed[2:0];
    @(posedge pclk);
    rx_frame_start <= 1'b0;
  endtask
  // Moves n bytes; each header length crossed queues one expected entry, header 2 only when above header 1.
  task automatic rx_add(input int n);
    int old;
    old = cnt;
    cnt += n;
    if (hdr1 != 0 && old < hdr1 && cnt >= hdr1) exp_q.push_back({13'h0, rx_addr_match, cnt[15:0]});
    if (hdr2 > hdr1 && old < hdr2 && cnt >= hdr2) exp_q.push_back({13'h0, rx_addr_match, cnt[15:0]});
    // Any crossing that queues an entry also raises the header event.
    if (hdr1 != 0 && old < hdr1 && cnt >= hdr1) ev[EV_HDR] = 1'b1;
    if (hdr2 > hdr1 && old < hdr2 && cnt >= hdr2) ev[EV_HDR] = 1'b1;
    @(posedge pclk);
    rx_bytes_valid <= 1'b1;
    rx_bytes_add   <= n[15:0];
    @(posedge pclk);
    rx_bytes_valid <= 1'b0;
  endtask
  task automatic fetch(input int n);
    @(posedge pclk);
    tx_fetch_done  <= 1'b1;
    tx_fetch_bytes <= n[15:0];
    @(posedge pclk);
    tx_fetch_done <= 1'b0;
    if (n >= tx_rem) begin
      tx_ptr = TXB;
      tx_rem = TXS;
      ev[EV_TX_WRAP] = 1'b1;
    end else begin
      tx_ptr += n;
      tx_rem -= n;
    end
    @(negedge pclk);
    `CHK(tx_fetch_addr, tx_ptr)
  endtask
  // Each accepted entry is checked, then the model pointer steps or wraps.
  always @(negedge pclk) begin
    if (presetn && sts_req === 1'b1 && sts_wr_done === 1'b1) begin
      `CHK(sts_addr, rx_ptr)
      `CHK(sts_entry, exp_q.pop_front())
      free--;
      if (free == 0) ev[EV_FREE_EMPTY] = 1'b1;
      if (rx_rem <= 8) ev[EV_RX_WRAP] = 1'b1;
      rx_ptr = (rx_rem <= 8) ? RXB : rx_ptr + 8;
      rx_rem = (rx_rem <= 8) ? RXS : rx_rem - 8;
    end
  end
  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (REGS[i]) begin
      apb(1'b0, REGS[i], 32'h0);
      `CHK(rd, REG_RESET)
    end
    apb(1'b0, 32'h01, 32'h0);
    `CHK(err, 1'b1)
    $display("reset test done");
    apb(1'b1, OFS_TX_DQ_BASE, TXB);
    apb(1'b1, OFS_TX_DQ_SIZE, TXS);
    apb(1'b1, OFS_TX_DQ_PTR, TXB);
    apb(1'b1, OFS_TX_DQ_REM, TXS);
    tx_ptr = TXB;
    tx_rem = TXS;
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      fetch((int'(seed[2:0]) + 1) * 4);
    end
    apb(1'b0, OFS_TX_DQ_REM, 32'h0);
    `CHK(rd, tx_rem)
    apb(1'b1, OFS_EVENT_MASK, 32'h1 << EV_TX_WRAP);
    repeat (2) @(negedge pclk);
    `CHK(irq, ev[EV_TX_WRAP])
    apb(1'b0, OFS_EVENT_STATUS, 32'h0);
    `CHK(rd, ev)
    ev = 32'h0;
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b0)
    $display("transmit test done");
    apb(1'b1, OFS_RX_STS_BASE, RXB);
    apb(1'b1, OFS_RX_STS_SIZE, RXS);
    apb(1'b1, OFS_RX_STS_PTR, RXB);
    apb(1'b1, OFS_RX_STS_REM, RXS);
    rx_ptr = RXB;
    rx_rem = RXS;
    frame(20, 40);
    rx_add(16);
    rx_add(8);
    repeat (4) @(negedge pclk);
    `CHK(sts_req, 1'b0)
    free += 3;
    apb(1'b1, OFS_RX_STS_FREE, 32'h3);
    rx_add(20);
    repeat (8) @(negedge pclk);
    `CHK(exp_q.size(), 0)
    apb(1'b0, OFS_RX_STS_FREE, 32'h0);
    `CHK(rd, {free[15:0], 16'h0})
    apb(1'b0, OFS_RX_STS_PTR, 32'h0);
    `CHK(rd, rx_ptr)
    apb(1'b0, OFS_RX_STS_REM, 32'h0);
    `CHK(rd, rx_rem)
    $display("status test done");
    slow <= 2'h2;
    frame(30, 10);
    rx_add(40);
    repeat (10) @(negedge pclk);
    `CHK(exp_q.size(), 0)
    apb(1'b0, OFS_RX_STS_FREE, 32'h0);
    `CHK(rd, {free[15:0], 16'h0})
    apb(1'b0, OFS_EVENT_STATUS, 32'h0);
    `CHK(rd, ev)
    $display("header order test done");
    finish_test();
  end
endmodule
